// ==== pkg/rss_map.svh ====
// Register offsets, field positions, reset values and timing constants
`ifndef RSS_MAP_SVH
`define RSS_MAP_SVH

// ************************************************************
// Register offsets
// ************************************************************
`define RSS_OFS_DLY_A 8'h20
`define RSS_OFS_DLY_B 8'h21
`define RSS_OFS_BUCK34 8'h23
`define RSS_OFS_BACKUP 8'h24
`define RSS_OFS_SWLDO 8'h25
`define RSS_OFS_STATUS 8'h2F

// ************************************************************
// Reset values and write masks
// ************************************************************
`define RSS_RST_DLY_A 8'h00
`define RSS_RST_DLY_B 8'h00
`define RSS_RST_BUCK34 8'h75
`define RSS_RST_BACKUP 8'h12
`define RSS_RST_SWLDO 8'h63
`define RSS_WMASK_BACKUP 8'h33
`define RSS_WMASK_DLY_B 8'h81
`define RSS_ZERO_BYTE 8'h00

// ************************************************************
// Field positions
// ************************************************************
`define RSS_F_HI 7:4
`define RSS_F_LO 3:0
`define RSS_F_BKB 5:4
`define RSS_F_BKA 1:0
`define RSS_F_FACTOR 7
`define RSS_F_DLY9 0

// ************************************************************
// Rail positions in the enable vector
// ************************************************************
`define RSS_RAIL_MEM 0
`define RSS_RAIL_IO 1
`define RSS_RAIL_LIN 2
`define RSS_RAIL_SW 3
`define RSS_RAIL_BKA 4
`define RSS_RAIL_BKB 5

// ************************************************************
// Strobe numbers and codes
// ************************************************************
`define RSS_STROBE_FIRST 4'h1
`define RSS_STROBE_SECOND 4'h2
`define RSS_STROBE_MAIN 4'h3
`define RSS_STROBE_LAST 4'hA
`define RSS_BK_CODE_S1 2'h1
`define RSS_BK_CODE_S2 2'h2

// ************************************************************
// Timing
// ************************************************************
`define RSS_CLK_KHZ 20000
`define RSS_GAP_SHORT_MS 2
`define RSS_GAP_LONG_MS 5
`define RSS_DOWN_FACTOR 10
`define RSS_CNT_ONE 24'h000001

`endif

// ==== pkg/rss_pkg.sv ====
// Types shared by the rail strobe assignment block
package rss_pkg;
  typedef logic [5:0] rss_rail_t;
  typedef logic [3:0] rss_strobe_t;
  typedef logic [7:0] rss_byte_t;
  typedef enum logic [1:0] {ST_IDLE, ST_STROBE, ST_GAP} rss_state_t;
endpackage

// ==== pkg/rss_dec_if.sv ====
// Carrier between the sequencer and the strobe decoder
`timescale 1ns/1ns
interface rss_dec_if;
  logic [3:0] strobe;
  logic [3:0] main_code [4];
  logic [1:0] bk_code [2];
  logic seal;
  logic [5:0] mask;
  modport src (output strobe, main_code, bk_code, seal, input mask);
  modport dec (input strobe, main_code, bk_code, seal, output mask);
endinterface

// ==== hdl/rss_decode.sv ====
// Strobe decoder: which rails a given strobe number acts on
`timescale 1ns/1ns
`include "rss_map.svh"
module rss_decode (
  input wire logic CORE_CLK,
  input wire logic SRST,
  rss_dec_if.dec dif
);
  import rss_pkg::*;

  // Main rail code matches a strobe only inside the 3h..Ah window
  function automatic logic main_hit(input logic [3:0] code,
                                    input logic [3:0] stb);
    main_hit = (code >= `RSS_STROBE_MAIN) && (code <= `RSS_STROBE_LAST)
               && (code == stb);
  endfunction

  // Backup rail code matches strobe one or two while the seal is intact
  function automatic logic bk_hit(input logic [1:0] code,
                                  input logic [3:0] stb,
                                  input logic seal);
    bk_hit = !seal && ((code == `RSS_BK_CODE_S1) ||
             (code == `RSS_BK_CODE_S2)) && ({2'h0, code} == stb);
  endfunction

  // ************************************************************
  // Decoding
  // ************************************************************
  // main rail window
  for (genvar i = 0; i < 4; i++) begin : g_main
    assign dif.mask[i] = main_hit(dif.main_code[i], dif.strobe);
  end

  for (genvar j = 0; j < 2; j++) begin : g_bk
    assign dif.mask[`RSS_RAIL_BKA + j] =
      bk_hit(dif.bk_code[j], dif.strobe, dif.seal);
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SRST);

  chk_main_bad_code: assert property (
    (dif.main_code[0] < `RSS_STROBE_MAIN ||
     dif.main_code[0] > `RSS_STROBE_LAST) |-> !dif.mask[0])
    else $error("out of window code matched a strobe");
  chk_bkb_field: assert property (
    dif.mask[`RSS_RAIL_BKB] |-> ({2'h0, dif.bk_code[1]} == dif.strobe
      && dif.bk_code[1] != 2'h0 && dif.bk_code[1] != 2'h3))
    else $error("backup b matched with bad code");
  chk_seal_blocks: assert property (
    dif.seal |-> !dif.mask[`RSS_RAIL_BKA] && !dif.mask[`RSS_RAIL_BKB])
    else $error("backup rail matched with seal broken");
endmodule // rss_decode

// ==== hdl/rss_top.sv ====
// Rail strobe assignment registers and strobe sequencer
//
// Notes on behaviour
// - Main rail codes 3h..Ah enable the rail at the strobe of that number.
// - Main rail codes 0h..2h and Bh..Fh keep the rail away from strobes.
// - Backup B field in bits 5-4: 1h strobe one, 2h two, else none.
// - Backup A field in bits 1-0, same encoding, reset code 2h.
// - Strobes one and two run only while the seal flag is 0.
// - Once the seal is broken backup rails are never turned off.
// - Each gap between strobes waits 2 ms, or 5 ms if its bit is set.
// - Factor bit multiplies gaps by ten on power-down only.
`timescale 1ns/1ns
`include "rss_map.svh"
module rss_top #(
  parameter int unsigned GAP_SHORT_CYC = `RSS_GAP_SHORT_MS * `RSS_CLK_KHZ,
  parameter int unsigned GAP_LONG_CYC = `RSS_GAP_LONG_MS * `RSS_CLK_KHZ
) (
  input wire logic CORE_CLK,
  input wire logic SRST,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire rss_pkg::rss_byte_t REG_ADDR,
  input wire rss_pkg::rss_byte_t REG_WDATA,
  input wire logic PASSWORD_OK,
  input wire logic FRESH_SEAL,
  input wire logic PWR_UP_REQ,
  input wire logic PWR_DOWN_REQ,
  output rss_pkg::rss_byte_t REG_RDATA,
  output logic REG_RVALID,
  output rss_pkg::rss_rail_t RAIL_EN,
  output rss_pkg::rss_strobe_t STROBE_NUM,
  output logic SEQ_BUSY
);
  import rss_pkg::*;

  localparam logic [23:0] SHORT_UP = 24'(GAP_SHORT_CYC);
  localparam logic [23:0] LONG_UP = 24'(GAP_LONG_CYC);
  localparam logic [23:0] SHORT_DN = 24'(GAP_SHORT_CYC * `RSS_DOWN_FACTOR);
  localparam logic [23:0] LONG_DN = 24'(GAP_LONG_CYC * `RSS_DOWN_FACTOR);

  rss_byte_t dly_a_reg, dly_b_reg, buck34_reg, backup_reg, swldo_reg;
  rss_byte_t rdata_reg, rdata_next;
  logic rvalid_reg;
  rss_state_t state_reg, state_next;
  rss_strobe_t strobe_reg, strobe_next;
  logic dir_reg, dir_next;
  logic [23:0] cnt_reg, cnt_next;
  rss_rail_t rail_reg, rail_next;
  logic busy_reg;

  // ************************************************************
  // Register access decode
  // ************************************************************
  wire wr_ok = REG_WR && PASSWORD_OK;
  wire hit_dly_a = REG_ADDR == `RSS_OFS_DLY_A;
  wire hit_dly_b = REG_ADDR == `RSS_OFS_DLY_B;
  wire hit_buck34 = REG_ADDR == `RSS_OFS_BUCK34;
  wire hit_backup = REG_ADDR == `RSS_OFS_BACKUP;
  wire hit_swldo = REG_ADDR == `RSS_OFS_SWLDO;
  wire hit_status = REG_ADDR == `RSS_OFS_STATUS;
  wire rss_byte_t status_val = {busy_reg, dir_reg, 2'h0, strobe_reg};

  // Read mux, unmapped offsets read zero
  assign rdata_next = hit_dly_a ? dly_a_reg :
                      hit_dly_b ? dly_b_reg :
                      hit_buck34 ? buck34_reg :
                      hit_backup ? backup_reg :
                      hit_swldo ? swldo_reg :
                      hit_status ? status_val : `RSS_ZERO_BYTE;

  // Configuration registers, written only with the password open
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      dly_a_reg <= `RSS_RST_DLY_A;
      dly_b_reg <= `RSS_RST_DLY_B;
      buck34_reg <= `RSS_RST_BUCK34;
      backup_reg <= `RSS_RST_BACKUP;
      swldo_reg <= `RSS_RST_SWLDO;
    end else if (wr_ok) begin
      if (hit_dly_a) dly_a_reg <= REG_WDATA;
      if (hit_dly_b) dly_b_reg <= REG_WDATA & `RSS_WMASK_DLY_B;
      if (hit_buck34) buck34_reg <= REG_WDATA;
      if (hit_backup) backup_reg <= REG_WDATA & `RSS_WMASK_BACKUP;
      if (hit_swldo) swldo_reg <= REG_WDATA;
    end
  end

  // Read data answered one cycle after the read strobe
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      rdata_reg <= `RSS_ZERO_BYTE;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= REG_RD;
      if (REG_RD) rdata_reg <= rdata_next;
    end
  end

  // ************************************************************
  // Strobe decoder
  // ************************************************************
  rss_dec_if dif ();
  assign dif.strobe = strobe_reg;
  assign dif.main_code[`RSS_RAIL_MEM] = buck34_reg[`RSS_F_LO];
  assign dif.main_code[`RSS_RAIL_IO] = buck34_reg[`RSS_F_HI];
  assign dif.main_code[`RSS_RAIL_LIN] = swldo_reg[`RSS_F_LO];
  assign dif.main_code[`RSS_RAIL_SW] = swldo_reg[`RSS_F_HI];
  assign dif.bk_code[0] = backup_reg[`RSS_F_BKA];
  assign dif.bk_code[1] = backup_reg[`RSS_F_BKB];
  assign dif.seal = FRESH_SEAL;

  rss_decode u_decode (
    .CORE_CLK(CORE_CLK),
    .SRST(SRST),
    .dif(dif)
  );

  // ************************************************************
  // Sequencer support terms
  // ************************************************************
  // backup rails shielded after seal break
  wire rss_rail_t keep_mask = FRESH_SEAL ?
    rss_rail_t'((1 << `RSS_RAIL_BKA) | (1 << `RSS_RAIL_BKB)) : '0;
  wire logic [8:0] dly_vec = {dly_b_reg[`RSS_F_DLY9], dly_a_reg};
  wire rss_strobe_t gap_idx = dir_reg ? rss_strobe_t'(strobe_reg - 4'h2) :
                                        rss_strobe_t'(strobe_reg - 4'h1);
  wire gap_long = dly_vec[gap_idx];
  wire slow_dn = dir_reg && dly_b_reg[`RSS_F_FACTOR];
  wire logic [23:0] gap_cyc = slow_dn ? (gap_long ? LONG_DN : SHORT_DN) :
                                        (gap_long ? LONG_UP : SHORT_UP);
  // seal skips strobes one and two
  wire rss_strobe_t low_end = FRESH_SEAL ? `RSS_STROBE_MAIN :
                                           `RSS_STROBE_FIRST;
  wire last_strobe = dir_reg ? (strobe_reg <= low_end) :
                               (strobe_reg == `RSS_STROBE_LAST);

  // ************************************************************
  // Sequencer next state
  // ************************************************************
  always_comb begin
    state_next = state_reg;
    strobe_next = strobe_reg;
    dir_next = dir_reg;
    cnt_next = cnt_reg;
    rail_next = rail_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (PWR_UP_REQ) begin
          dir_next = 1'b0;
          strobe_next = low_end;
          state_next = ST_STROBE;
        end else if (PWR_DOWN_REQ) begin
          dir_next = 1'b1;
          strobe_next = `RSS_STROBE_LAST;
          state_next = ST_STROBE;
        end
      end
      ST_STROBE: begin
        if (dir_reg) rail_next = rail_reg & ~(dif.mask & ~keep_mask);
        else rail_next = rail_reg | dif.mask;
        if (last_strobe) begin
          state_next = ST_IDLE;
        end else begin
          // Strobe cycle is the first cycle of the gap
          cnt_next = gap_cyc - `RSS_CNT_ONE;
          state_next = ST_GAP;
        end
      end
      ST_GAP: begin
        if (cnt_reg <= `RSS_CNT_ONE) begin
          strobe_next = dir_reg ? rss_strobe_t'(strobe_reg - 4'h1) :
                                  rss_strobe_t'(strobe_reg + 4'h1);
          state_next = ST_STROBE;
        end else begin
          cnt_next = cnt_reg - `RSS_CNT_ONE;
        end
      end
    endcase
  end

  // Sequencer state registers
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      state_reg <= ST_IDLE;
      strobe_reg <= '0;
      dir_reg <= 1'b0;
      cnt_reg <= '0;
      rail_reg <= '0;
      busy_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      strobe_reg <= strobe_next;
      dir_reg <= dir_next;
      cnt_reg <= cnt_next;
      rail_reg <= rail_next;
      busy_reg <= state_next != ST_IDLE;
    end
  end

  assign REG_RDATA = rdata_reg;
  assign REG_RVALID = rvalid_reg;
  assign RAIL_EN = rail_reg;
  assign STROBE_NUM = strobe_reg;
  assign SEQ_BUSY = busy_reg;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SRST);

  wire gap_entry = state_reg == ST_STROBE && state_next == ST_GAP;

  chk_up_enable: assert property (
    (state_reg == ST_STROBE && !dir_reg &&
     buck34_reg[`RSS_F_LO] == strobe_reg &&
     strobe_reg >= `RSS_STROBE_MAIN) |=> RAIL_EN[`RSS_RAIL_MEM])
    else $error("memory buck not enabled at its strobe");
  chk_bka_reset: assert property (
    disable iff (1'b0)
    $fell(SRST) |-> backup_reg[`RSS_F_BKA] == `RSS_BK_CODE_S2)
    else $error("backup a code not at reset value");
  chk_seal_skip: assert property (
    (state_reg == ST_STROBE && FRESH_SEAL) |->
      strobe_reg >= `RSS_STROBE_MAIN)
    else $error("strobe one or two run with seal broken");
  chk_backup_held: assert property (
    (FRESH_SEAL && RAIL_EN[`RSS_RAIL_BKA]) |=> RAIL_EN[`RSS_RAIL_BKA])
    else $error("backup a turned off after seal break");
  chk_gap_up_len: assert property (
    (gap_entry && !dir_reg) |=>
      cnt_reg == (($past(gap_long) ? LONG_UP : SHORT_UP) - `RSS_CNT_ONE))
    else $error("power-up gap length wrong");
  chk_gap_down_factor: assert property (
    (gap_entry && dir_reg && dly_b_reg[`RSS_F_FACTOR]) |=>
      cnt_reg == (($past(gap_long) ? LONG_DN : SHORT_DN) - `RSS_CNT_ONE))
    else $error("power-down gap not multiplied");
  chk_down_order: assert property (
    (state_reg == ST_GAP && dir_reg && cnt_reg == `RSS_CNT_ONE) |=>
      state_reg == ST_STROBE && strobe_reg == $past(strobe_reg) - 4'h1)
    else $error("power-down strobe order wrong");
  chk_gap_expiry: assert property (
    (state_reg == ST_GAP && cnt_reg == `RSS_CNT_ONE) |=>
      state_reg == ST_STROBE ##1 state_reg != ST_STROBE)
    else $error("gap did not end in one strobe");

  cov_up_done: cover property (
    state_reg == ST_STROBE && !dir_reg && strobe_reg == `RSS_STROBE_LAST);
  cov_down_slow: cover property (gap_entry && slow_dn);
  cov_seal_up: cover property (PWR_UP_REQ && FRESH_SEAL &&
                               state_reg == ST_IDLE);
endmodule // rss_top

// ==== tb/rss_host.sv ====
// Host processor model driving the register strobe port
`timescale 1ns/1ns
module rss_host (
  input wire logic clk,
  output logic reg_wr,
  output logic reg_rd,
  output rss_pkg::rss_byte_t reg_addr,
  output rss_pkg::rss_byte_t reg_wdata,
  output logic password_ok,
  input wire rss_pkg::rss_byte_t reg_rdata,
  input wire logic reg_rvalid
);
  import rss_pkg::*;
  // Idle port at time zero
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    password_ok = 1'b0;
  end
  // One-cycle write; released lines show the inverse of the last value
  task automatic wr(input rss_byte_t a, input rss_byte_t d, input logic p);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    password_ok <= p;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    password_ok <= ~p;
  endtask
  // One-cycle read; answer is taken one cycle after the strobe edge
  task automatic rd(input rss_byte_t a, output rss_byte_t d, output logic v);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    v = reg_rvalid;
    d = reg_rdata;
  endtask
endmodule // rss_host

// ==== tb/rss_top_test.sv ====
// Self-checking bench for the rail strobe sequencer
`timescale 1ns/1ns
module rss_top_test;
  import rss_pkg::*;
  localparam int NS = 4;
  localparam int NL = 10;
  logic clk, srst, up_req, dn_req, seal, busy, wr, rd, pw, rvalid, rd_v;
  rss_byte_t addr, wdata, rdata, rd_d;
  rss_rail_t rails, rails_m;
  rss_strobe_t stb;
  rss_byte_t regs [256];
  int n_mismatch = 0;
  int checks = 0;
  int rnd;

  // ************************************************************
  // Design and host model
  // ************************************************************
  rss_top #(.GAP_SHORT_CYC(NS), .GAP_LONG_CYC(NL)) u_dut (
    .CORE_CLK(clk), .SRST(srst), .REG_WR(wr), .REG_RD(rd),
    .REG_ADDR(addr), .REG_WDATA(wdata), .PASSWORD_OK(pw),
    .FRESH_SEAL(seal), .PWR_UP_REQ(up_req), .PWR_DOWN_REQ(dn_req),
    .REG_RDATA(rdata), .REG_RVALID(rvalid), .RAIL_EN(rails),
    .STROBE_NUM(stb), .SEQ_BUSY(busy));
  rss_host u_host (
    .clk(clk), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr),
    .reg_wdata(wdata), .password_ok(pw), .reg_rdata(rdata),
    .reg_rvalid(rvalid));

  // ************************************************************
  // Checking and closing
  // ************************************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Rails acted on by strobe s under the current codes
  function automatic rss_rail_t act(input int s, input logic sl);
    rss_rail_t m;
    int c [6];
    c = '{regs[8'h23][3:0], regs[8'h23][7:4], regs[8'h25][3:0],
          regs[8'h25][7:4], regs[8'h24][1:0], regs[8'h24][5:4]};
    for (int i = 0; i < 6; i++) begin
      if (i < 4) begin
        m[i] = (c[i] == s) && (s >= 3) && (s <= 10);
      end else begin
        m[i] = (c[i] == s) && (s <= 2) && !sl;
      end
    end
    return m;
  endfunction

  // Write through the host and mirror it into the model
  task automatic put(input rss_byte_t a, input rss_byte_t d, input logic p);
    u_host.wr(a, d, p);
    if (p && a inside {8'h20, 8'h21, 8'h23, 8'h24, 8'h25}) begin
      regs[a] = d & (a == 8'h24 ? 8'h33 : (a == 8'h21 ? 8'h81 : 8'hFF));
    end
  endtask
  // Read back every writable register plus one unmapped address
  task automatic scan;
    rss_byte_t a [6] = '{8'h20, 8'h21, 8'h23, 8'h24, 8'h25, 8'h30};
    for (int i = 0; i < 6; i++) begin
      u_host.rd(a[i], rd_d, rd_v);
      check(rd_v, 1'b1);
      check(rd_d, regs[a[i]]);
    end
  endtask

  // Run one sequence, checking order, gap lengths and rails per strobe
  task automatic run_seq(input logic down, input logic sl);
    int s, cnt, g, lo, last;
    logic [8:0] dly;
    dly = {regs[8'h21][0], regs[8'h20]};
    last = down ? (sl ? 3 : 1) : 10;
    @(posedge clk);
    seal <= sl;
    up_req <= !down;
    dn_req <= down;
    @(posedge clk);
    up_req <= 1'b0;
    dn_req <= 1'b0;
    #1;
    s = down ? 10 : (sl ? 3 : 1);
    check(busy, 1'b1);
    check(stb, 16'(s));
    cnt = 0;
    while (busy === 1'b1 && cnt < 2000) begin
      @(posedge clk);
      #1;
      cnt++;
      if (busy === 1'b1 && stb !== s[3:0]) begin
        lo = down ? s - 1 : s;
        g = dly[lo - 1] ? NL : NS;
        g = (down && regs[8'h21][7]) ? g * 10 : g;
        check(16'(cnt), 16'(g));
        check(stb, 16'(down ? s - 1 : s + 1));
        rails_m = down ? rails_m & ~act(s, sl) : rails_m | act(s, sl);
        check(rails, rails_m);
        s = down ? s - 1 : s + 1;
        cnt = 0;
      end
    end
    rails_m = down ? rails_m & ~act(s, sl) : rails_m | act(s, sl);
    check(rails, rails_m);
    check(16'(s), 16'(last));
  endtask

  // ************************************************************
  // Clock, watchdog and main sequence
  // ************************************************************
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (40000) @(posedge clk);
    n_mismatch++;
    end_sim();
  end
  initial begin
    srst = 1'b1;
    up_req = 1'b0;
    dn_req = 1'b0;
    seal = 1'b0;
    rails_m = '0;
    foreach (regs[i]) regs[i] = 8'h00;
    regs[8'h23] = 8'h75;
    regs[8'h24] = 8'h12;
    regs[8'h25] = 8'h63;
    rnd = $urandom(32'h973763C4);
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    scan();
    put(8'h24, 8'hFF, 1'b1);
    put(8'h23, 8'h00, 1'b0);
    scan();
    // Walk every main code through two fields, the rest random
    for (int it = 0; it < 8; it++) begin
      put(8'h20, 8'($urandom), 1'b1);
      put(8'h21, 8'($urandom), 1'b1);
      put(8'h23, {4'(2 * it + 1), 4'(2 * it)}, 1'b1);
      put(8'h24, 8'($urandom), 1'b1);
      put(8'h25, 8'($urandom), 1'b1);
      run_seq(1'b0, it[0]);
      u_host.rd(8'h2F, rd_d, rd_v);
      check(rd_d, 8'h0A);
      run_seq(1'b1, it[1]);
    end
    end_sim();
  end
endmodule // rss_top_test
